/* verilog/mcs_status_regs.v */
`timescale 1ns/1ns
`include "mcs_map.vh"

// What this block does
// - tx size ecc fault sets flag and flushes whole tx fifo
// - rx size ecc fault sets flag and clears that rx fifo
// - generic mode: serial crc error sets link error flag; unused in chunk mode
// - gap shorter than threshold drops next frame and sets gap flag
// - read-only urgent frame indicator, never drives interrupt, generic mode only
// - generic mode, store-and-forward: frame available while a complete frame is queued
// - generic mode, cut-through: available at threshold or once end of frame arrived
// - urgent queue is delivered before normal queue
// - tx done on completion, also needing empty fifo when qualifier set
// - tx done only in generic mode, cleared only by host writing one
// - link change sticky until host writes one
// - current link state read-only, raises no event itself
// - status at word 0x09, resets zero, upper and error bits write-one-clear
// - buffer status bits 15:8 give transmit credits, chunk mode
// - credits saturated at 31 into 5-bit footer field
// - buffer status bits 7:0 give receive chunks available
// - buffer status at 0x0B read-only, resets 0x00007700
// - mask at 0x0D resets 0x43FA1F1A, every writable bit set; set bit blocks interrupt pin
module mcs_status_regs #(
  parameter GAP_W      = 16,
  parameter THRESH_W   = 16,
  parameter COUNT_W    = 8,
  parameter TX_CREDITS = 8'h77
) (
  input  wire                clock,
  input  wire                sys_rst,
  input  wire                spiSclk,
  input  wire                spiCsN,
  input  wire                spiMosi,
  output wire                misoOut,
  output wire                misoDriveN,
  input  wire                chunkMode,
  input  wire                storeForward,
  input  wire                txRdyOnEmpty,
  input  wire [GAP_W-1:0]    receiveGapThreshold,
  input  wire [THRESH_W-1:0] cutThroughReceiveThreshold,
  input  wire                portLinkUp,
  input  wire                txSizeEccFault,
  input  wire                rxSizeEccFault,
  input  wire                rxEccOnUrgent,
  input  wire                txFrameDone,
  input  wire                txFifoEmpty,
  input  wire                rxFrameStart,
  input  wire                rxFrameEnd,
  input  wire [COUNT_W-1:0]  urgentFrameCount,
  input  wire [COUNT_W-1:0]  normalFrameCount,
  input  wire [THRESH_W-1:0] cutThroughBytes,
  input  wire                eofReceived,
  input  wire                txChunkTaken,
  input  wire                txChunkFreed,
  input  wire                rxChunkStored,
  input  wire                rxChunkRead,
  output reg                 txFifoFlush,
  output reg                 rxFifoFlushUrgent,
  output reg                 rxFifoFlushNormal,
  output reg                 dropNextFrame,
  output reg                 deliverUrgentFirst,
  output reg  [4:0]          footerCredit,
  output reg                 interruptN
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  wire [6:0]       accessAddr;
  wire             writeStrobe;
  wire [31:0]      writeData;
  wire             crcGood;
  reg  [31:0]      readWord;
  reg              txEccFlag;
  reg              rxEccFlag;
  reg              linkErrFlag;
  reg              gapFlag;
  reg              txDoneFlag;
  reg              linkChgFlag;
  reg              linkUp;
  reg              urgentAvail;
  reg              frameAvail;
  reg  [31:0]      maskReg;
  reg  [7:0]       txCredit;
  reg  [7:0]       rxChunks;
  reg  [GAP_W-1:0] gapCount;
  reg              gapArmed;
  wire             writeAccepted;
  wire             crcFault;
  wire [31:0]      statusClear;
  wire [31:0]      statusWord;
  wire [31:0]      bufferWord;
  wire [31:0]      maskWord;
  wire             shortGap;
  wire             txDoneEvent;
  wire             availNow;

  function isAddr;
    input [6:0] addr;
    input [6:0] target;
    begin
      isAddr = (addr == target);
    end
  endfunction

  // ------------------------------------------------------------
  // serial register port
  // ------------------------------------------------------------
  mcs_spi_link link (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .spiSclk     (spiSclk),
    .spiCsN      (spiCsN),
    .spiMosi     (spiMosi),
    .readWord    (readWord),
    .accessAddr  (accessAddr),
    .writeStrobe (writeStrobe),
    .writeData   (writeData),
    .crcGood     (crcGood),
    .misoOut     (misoOut),
    .misoDriveN  (misoDriveN)
  );

  // in generic mode a bad crc discards the write so a corrupted clear never lands; chunk mode accepts it
  assign crcFault      = writeStrobe & ~crcGood & ~chunkMode;
  assign writeAccepted = writeStrobe & (crcGood | chunkMode);

  // only write-one-clear positions react; read-only bits ignore writes
  assign statusClear = (writeAccepted && isAddr(accessAddr, `MCS_ADDR_STATUS)) ?
                       (writeData & `MCS_STATUS_W1C) : 32'h00000000;

  // ------------------------------------------------------------
  // read words
  // ------------------------------------------------------------
  assign statusWord = {19'h00000,
                       txEccFlag,
                       rxEccFlag,
                       linkErrFlag,
                       1'b0,
                       gapFlag,
                       2'h0,
                       urgentAvail,
                       frameAvail,
                       txDoneFlag,
                       1'b0,
                       linkChgFlag,
                       linkUp};

  assign bufferWord = {16'h0000, txCredit, rxChunks};

  // reserved mask bits read their fixed reset pattern
  assign maskWord = (`MCS_MASK_RST & ~`MCS_MASK_RW) | (maskReg & `MCS_MASK_RW);

  always @* begin
    readWord = 32'h00000000;
    if (isAddr(accessAddr, `MCS_ADDR_STATUS))
      readWord = statusWord;
    else if (isAddr(accessAddr, `MCS_ADDR_BUFFER))
      readWord = bufferWord;
    else if (isAddr(accessAddr, `MCS_ADDR_MASK))
      readWord = maskWord;
  end

  // ------------------------------------------------------------
  // mask register
  // ------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      maskReg <= `MCS_MASK_RST;
    end else if (writeAccepted && isAddr(accessAddr, `MCS_ADDR_MASK)) begin
      maskReg <= writeData & `MCS_MASK_RW;
    end
  end

  // ------------------------------------------------------------
  // receive gap measurement, in clock cycles
  // ------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gapCount <= {GAP_W{1'b0}};
      gapArmed <= 1'b0;
    end else if (rxFrameEnd) begin
      gapCount <= {GAP_W{1'b0}};
      gapArmed <= 1'b1;
    end else if (rxFrameStart) begin
      gapArmed <= 1'b0;
    end else if (gapArmed && gapCount != {GAP_W{1'b1}}) begin
      gapCount <= gapCount + {{(GAP_W-1){1'b0}}, 1'b1};
    end
  end

  // the very first frame after reset has no gap to judge
  assign shortGap = rxFrameStart & gapArmed & (gapCount < receiveGapThreshold);

  // ------------------------------------------------------------
  // sticky flags: a set in the clearing cycle wins; linkUp just follows portLinkUp
  // ------------------------------------------------------------
  assign txDoneEvent = txFrameDone & (~txRdyOnEmpty | txFifoEmpty) & ~chunkMode;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      txEccFlag   <= 1'b0;
      rxEccFlag   <= 1'b0;
      linkErrFlag <= 1'b0;
      gapFlag     <= 1'b0;
      txDoneFlag  <= 1'b0;
      linkChgFlag <= 1'b0;
      linkUp      <= 1'b0;
    end else begin
      txEccFlag   <= (txEccFlag & ~statusClear[`MCS_BIT_TX_ECC]) | txSizeEccFault;
      rxEccFlag   <= (rxEccFlag & ~statusClear[`MCS_BIT_RX_ECC]) | rxSizeEccFault;
      linkErrFlag <= (linkErrFlag & ~statusClear[`MCS_BIT_LINK_ERR]) | crcFault;
      gapFlag     <= (gapFlag & ~statusClear[`MCS_BIT_GAP]) | shortGap;
      txDoneFlag  <= (txDoneFlag & ~statusClear[`MCS_BIT_TX_DONE]) | txDoneEvent;
      linkChgFlag <= (linkChgFlag & ~statusClear[`MCS_BIT_LINK_CHG]) | (portLinkUp ^ linkUp);
      linkUp      <= portLinkUp;
    end
  end

  // ------------------------------------------------------------
  // fifo actions
  // ------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      txFifoFlush       <= 1'b0;
      rxFifoFlushUrgent <= 1'b0;
      rxFifoFlushNormal <= 1'b0;
      dropNextFrame     <= 1'b0;
    end else begin
      txFifoFlush       <= txSizeEccFault;
      rxFifoFlushUrgent <= rxSizeEccFault & rxEccOnUrgent;
      rxFifoFlushNormal <= rxSizeEccFault & ~rxEccOnUrgent;
      dropNextFrame     <= shortGap;
    end
  end

  // ------------------------------------------------------------
  // receive readiness
  // ------------------------------------------------------------
  assign availNow = storeForward ?
                    ((urgentFrameCount != {COUNT_W{1'b0}}) ||
                     (normalFrameCount != {COUNT_W{1'b0}})) :
                    ((cutThroughBytes >= cutThroughReceiveThreshold) || eofReceived);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      urgentAvail        <= 1'b0;
      frameAvail         <= 1'b0;
      deliverUrgentFirst <= 1'b0;
    end else begin
      urgentAvail        <= ~chunkMode & (urgentFrameCount != {COUNT_W{1'b0}});
      frameAvail         <= ~chunkMode & availNow;
      deliverUrgentFirst <= (urgentFrameCount != {COUNT_W{1'b0}});
    end
  end

  // ------------------------------------------------------------
  // credits and receive chunks
  // ------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      txCredit <= `MCS_CREDIT_RST;
    end else if (txSizeEccFault) begin
      // the flush frees every buffer at once
      txCredit <= TX_CREDITS;
    end else if (txChunkTaken && !txChunkFreed && txCredit != 8'h00) begin
      txCredit <= txCredit - 8'h01;
    end else if (txChunkFreed && !txChunkTaken && txCredit != TX_CREDITS) begin
      txCredit <= txCredit + 8'h01;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rxChunks <= 8'h00;
    end else if (rxChunkStored && !rxChunkRead && rxChunks != 8'hFF) begin
      rxChunks <= rxChunks + 8'h01;
    end else if (rxChunkRead && !rxChunkStored && rxChunks != 8'h00) begin
      rxChunks <= rxChunks - 8'h01;
    end
  end

  // footer field is only five bits wide, so large counts pin at 31
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      footerCredit <= 5'h1F;
    end else if (txCredit > `MCS_FOOTER_SAT) begin
      footerCredit <= 5'h1F;
    end else begin
      footerCredit <= txCredit[4:0];
    end
  end

  // ------------------------------------------------------------
  // interrupt pin: urgent indicator and link state never reach it
  // ------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      interruptN <= 1'b1;
    end else begin
      interruptN <= ~|(statusWord & ~maskWord & `MCS_IRQ_SOURCES);
    end
  end

endmodule

/* verilog/mcs_map.vh */
`ifndef MCS_MAP_VH
`define MCS_MAP_VH

// ------------------------------------------------------------
// register word addresses
// ------------------------------------------------------------
`define MCS_ADDR_STATUS 7'h09
`define MCS_ADDR_BUFFER 7'h0B
`define MCS_ADDR_MASK   7'h0D

// ------------------------------------------------------------
// reset values and access masks
// ------------------------------------------------------------
`define MCS_STATUS_RST  32'h00000000
`define MCS_BUFFER_RST  32'h00007700
`define MCS_MASK_RST    32'h43FA1F1A
`define MCS_MASK_RW     32'h00001F1A
`define MCS_STATUS_W1C  32'hFFFFFF0A
`define MCS_IRQ_SOURCES 32'h00001D1A
`define MCS_CREDIT_RST  8'h77
`define MCS_FOOTER_SAT  8'h1F

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define MCS_BIT_TX_ECC   12
`define MCS_BIT_RX_ECC   11
`define MCS_BIT_LINK_ERR 10
`define MCS_BIT_GAP      8
`define MCS_BIT_URGENT   5
`define MCS_BIT_AVAIL    4
`define MCS_BIT_TX_DONE  3
`define MCS_BIT_LINK_CHG 1
`define MCS_BIT_LINK_UP  0

// ------------------------------------------------------------
// serial access framing
// ------------------------------------------------------------
`define MCS_CRC_POLY    8'h07
`define MCS_CMD_LAST    6'h07
`define MCS_DATA_LAST   6'h27
`define MCS_FRAME_LAST  6'h2F

`endif

/* verilog/mcs_spi_link.v */
`timescale 1ns/1ns
`include "mcs_map.vh"

module mcs_spi_link (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        spiSclk,
  input  wire        spiCsN,
  input  wire        spiMosi,
  input  wire [31:0] readWord,
  output reg  [6:0]  accessAddr,
  output reg         writeStrobe,
  output reg  [31:0] writeData,
  output reg         crcGood,
  output reg         misoOut,
  output reg         misoDriveN
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg        sclkMeta;
  reg        sclkSync;
  reg        sclkLast;
  reg        csMeta;
  reg        csSync;
  reg        mosiMeta;
  reg        mosiSync;
  reg [5:0]  bitCount;
  reg        isWrite;
  reg        loadPending;
  reg [31:0] shiftIn;
  reg [31:0] shiftOut;
  reg [7:0]  crc;
  wire       sclkRise;
  wire       sclkFall;

  // serial crc-8, msb first; a good frame leaves zero
  function [7:0] crcStep;
    input [7:0] c;
    input       b;
    begin
      crcStep = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `MCS_CRC_POLY : 8'h00);
    end
  endfunction

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      csMeta   <= 1'b1;
      csSync   <= 1'b1;
      mosiMeta <= 1'b0;
      mosiSync <= 1'b0;
    end else begin
      sclkMeta <= spiSclk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      csMeta   <= spiCsN;
      csSync   <= csMeta;
      mosiMeta <= spiMosi;
      mosiSync <= mosiMeta;
    end
  end

  assign sclkRise = sclkSync & ~sclkLast;
  assign sclkFall = ~sclkSync & sclkLast;

  // ------------------------------------------------------------
  // framing: 8 command bits, 32 data bits, 8 crc bits on writes
  // ------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bitCount    <= 6'h00;
      isWrite     <= 1'b0;
      loadPending <= 1'b0;
      shiftIn     <= 32'h00000000;
      shiftOut    <= 32'h00000000;
      crc         <= 8'h00;
      accessAddr  <= 7'h00;
      writeStrobe <= 1'b0;
      writeData   <= 32'h00000000;
      crcGood     <= 1'b0;
      misoOut     <= 1'b0;
      misoDriveN  <= 1'b1;
    end else begin
      writeStrobe <= 1'b0;
      if (csSync) begin
        // early deselect abandons the access, nothing is written
        bitCount    <= 6'h00;
        crc         <= 8'h00;
        loadPending <= 1'b0;
        misoOut     <= 1'b0;
        misoDriveN  <= 1'b1;
      end else begin
        if (loadPending) begin
          shiftOut    <= readWord;
          loadPending <= 1'b0;
        end
        if (sclkRise && bitCount <= `MCS_FRAME_LAST) begin
          shiftIn  <= {shiftIn[30:0], mosiSync};
          crc      <= crcStep(crc, mosiSync);
          bitCount <= bitCount + 6'h01;
          if (bitCount == `MCS_CMD_LAST) begin
            accessAddr  <= {shiftIn[5:0], mosiSync};
            isWrite     <= shiftIn[6];
            loadPending <= ~shiftIn[6];
          end
          if (bitCount == `MCS_DATA_LAST)
            writeData <= {shiftIn[30:0], mosiSync};
          if (bitCount == `MCS_FRAME_LAST && isWrite) begin
            writeStrobe <= 1'b1;
            crcGood     <= (crcStep(crc, mosiSync) == 8'h00);
          end
        end
        if (sclkFall && !isWrite && bitCount > `MCS_CMD_LAST) begin
          misoOut    <= shiftOut[31];
          shiftOut   <= {shiftOut[30:0], 1'b0};
          misoDriveN <= 1'b0;
        end
      end
    end
  end

endmodule

/* sim/mcs_properties.sv */
`timescale 1ns/1ns
module mcs_properties #(
  parameter GAP_W      = 16,
  parameter COUNT_W    = 8,
  parameter TX_CREDITS = 8'h77
) (
  input wire               clock,
  input wire               sys_rst,
  input wire               spiCsN,
  input wire               misoDriveN,
  input wire               txSizeEccFault,
  input wire               rxSizeEccFault,
  input wire               rxEccOnUrgent,
  input wire               rxFrameStart,
  input wire               rxFrameEnd,
  input wire [GAP_W-1:0]   receiveGapThreshold,
  input wire [COUNT_W-1:0] urgentFrameCount,
  input wire               txFifoFlush,
  input wire               rxFifoFlushUrgent,
  input wire               rxFifoFlushNormal,
  input wire               dropNextFrame,
  input wire               deliverUrgentFirst,
  input wire [4:0]         footerCredit
);
  localparam int SAT = (TX_CREDITS > 31) ? 31 : TX_CREDITS;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // -------------------------------------------------
  // sequences
  // -------------------------------------------------
  sequence s_short_gap;
    (rxFrameEnd && receiveGapThreshold > 8) ##2 rxFrameStart;
  endsequence
  sequence s_cs_idle;
    spiCsN [*8];
  endsequence
  // -------------------------------------------------
  // properties
  // -------------------------------------------------
  chk_tx_flush: assert property (txSizeEccFault |=> txFifoFlush)
    else $error("tx flush missing");
  chk_flush_cause: assert property (txFifoFlush |-> $past(txSizeEccFault))
    else $error("tx flush without fault");
  chk_rx_urgent: assert property (rxSizeEccFault && rxEccOnUrgent |=> rxFifoFlushUrgent && !rxFifoFlushNormal)
    else $error("urgent rx flush wrong");
  chk_rx_normal: assert property (rxSizeEccFault && !rxEccOnUrgent |=> rxFifoFlushNormal && !rxFifoFlushUrgent)
    else $error("normal rx flush wrong");
  chk_gap_drop: assert property (s_short_gap |=> dropNextFrame)
    else $error("short gap not dropped");
  chk_drop_cause: assert property (dropNextFrame |-> $past(rxFrameStart))
    else $error("drop without frame start");
  // the first edge after release still shows the reset value, hence the guard
  chk_urgent_first: assert property (!$past(sys_rst) |-> deliverUrgentFirst == ($past(urgentFrameCount) != 0))
    else $error("urgent priority wrong");
  chk_footer_sat: assert property (txSizeEccFault |-> ##3 footerCredit == SAT)
    else $error("footer credit not reloaded");
  chk_miso_idle: assert property (s_cs_idle |-> misoDriveN)
    else $error("miso driven while deselected");
endmodule

bind mcs_status_regs mcs_properties #(.GAP_W(GAP_W), .COUNT_W(COUNT_W), .TX_CREDITS(TX_CREDITS)) i_mcs_properties (.*);

/* sim/mcs_spi_host.sv */
`timescale 1ns/1ns
module mcs_spi_host (
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  input  wire  misoOut,
  input  wire  misoDriveN
);
  logic lastMiso = 1'b0;
  // a released line shows the inverse of its last value, never a stale match
  wire  misoWire = misoDriveN ? ~lastMiso : misoOut;
  always @(misoOut) if (!misoDriveN) lastMiso = misoOut;
  initial begin
    spiSclk = 1'b0;
    spiCsN  = 1'b1;
    spiMosi = 1'b0;
  end
  // -------------------------------------------------
  // one access, mode 0, msb first
  // -------------------------------------------------
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [31:0] d,
                      input logic bad, output logic [31:0] q);
    logic [47:0] f;
    logic        fb;
    int          n;
    f = {wr, a, d, 8'h00};
    q = 32'h00000000;
    n = wr ? 48 : 40;
    for (int i = 47; i >= 8; i--) begin
      fb = f[7] ^ f[i];
      f[7:0] = {f[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    f[0] = f[0] ^ bad;
    spiCsN = 1'b0;
    // writes of ones clear flags, so the host clears only what it names
    for (int i = 0; i < n; i++) begin
      spiMosi = f[47-i];
      #62;
      if (i >= 8 && i < 40) q[39-i] = misoWire;
      spiSclk = 1'b1;
      #63;
      spiSclk = 1'b0;
    end
    #62;
    spiCsN = 1'b1;
    spiMosi = ~spiMosi;
    #120;
  endtask
endmodule

/* sim/mcs_status_regs_test.sv */
`timescale 1ns/1ns
module mcs_status_regs_test;
  localparam logic [6:0] aSt = 7'h09, aBuf = 7'h0B, aMask = 7'h0D;
  logic        clock, sys_rst, chunkMode, storeForward, txRdyOnEmpty, portLinkUp;
  logic        txSizeEccFault, rxSizeEccFault, rxEccOnUrgent, txFrameDone, txFifoEmpty;
  logic        rxFrameStart, rxFrameEnd, eofReceived, txChunkTaken, txChunkFreed;
  logic        rxChunkStored, rxChunkRead;
  logic [15:0] receiveGapThreshold, cutThroughReceiveThreshold, cutThroughBytes;
  logic [7:0]  urgentFrameCount, normalFrameCount;
  logic [31:0] rdWord;
  logic [31:0] expQ[$];
  logic [3:0]  pulseQ[$];
  wire         spiSclk, spiCsN, spiMosi, misoOut, misoDriveN, txFifoFlush, rxFifoFlushUrgent;
  wire         rxFifoFlushNormal, dropNextFrame, deliverUrgentFirst, interruptN;
  wire  [4:0]  footerCredit;
  wire  [3:0]  pulses = {txFifoFlush, rxFifoFlushUrgent, rxFifoFlushNormal, dropNextFrame};
  int          err_total, checks_done, n, k, c;
  event        rdDone;

  mcs_status_regs i_mcs_status_regs (.*);
  mcs_spi_host    i_mcs_spi_host (.*);
  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic chk_pulse(input logic [3:0] e, input logic [3:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("ERROR action pulses expected %h seen %h", e, s);
    end
  endtask
  task give_verdict;
    if (pulseQ.size() != 0) err_total++;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task step;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] q;
    expQ.push_back(e);
    i_mcs_spi_host.xfer(1'b1 ^ 1'b1, a, 32'h00000000, 1'b0, q);
    rdWord = q;
    ->rdDone;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic bad = 1'b0);
    logic [31:0] q;
    i_mcs_spi_host.xfer(1'b1, a, d, bad, q);
  endtask
  // -------------------------------------------------
  // monitors
  // -------------------------------------------------
  always @(rdDone) chk_word("read data", expQ.pop_front(), rdWord);
  // an unexpected pulse meets an empty queue and compares against zero
  // sampled mid-cycle, where a one-cycle pulse has settled
  always @(negedge clock)
    if (!sys_rst && pulses !== 4'h0) chk_pulse(pulseQ.size() ? pulseQ.pop_front() : 4'h0, pulses);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #800000;
    err_total++;
    give_verdict;
  end
  // -------------------------------------------------
  // tests
  // -------------------------------------------------
  initial begin
    {chunkMode, txRdyOnEmpty, portLinkUp, txSizeEccFault, rxSizeEccFault, rxEccOnUrgent} = 6'h00;
    {txFrameDone, txFifoEmpty, rxFrameStart, rxFrameEnd, eofReceived} = 5'h00;
    {txChunkTaken, txChunkFreed, rxChunkStored, rxChunkRead} = 4'h0;
    {urgentFrameCount, normalFrameCount, cutThroughBytes} = 32'h00000000;
    receiveGapThreshold = 16'h0014;
    cutThroughReceiveThreshold = 16'h0040;
    storeForward = 1'b1;
    sys_rst = 1'b1;
    void'($urandom(32'h3052));
    repeat (6) step;
    sys_rst = 1'b0;
    rd(aSt, 32'h00000000);
    rd(aBuf, 32'h00007700);
    rd(aMask, 32'h43FA1F1A);
    rd(7'h20, 32'h00000000);
    wr(aBuf, 32'hFFFFFFFF);
    rd(aBuf, 32'h00007700);
    chk_word("interrupt pin", 32'h00000001, {31'h0, interruptN});
    step; txSizeEccFault = 1'b1; pulseQ.push_back(4'h8); step; txSizeEccFault = 1'b0;
    rd(aSt, 32'h00001000);
    rxEccOnUrgent = 1'b1; rxSizeEccFault = 1'b1; pulseQ.push_back(4'h4); step;
    rxEccOnUrgent = 1'b0; pulseQ.push_back(4'h2); step; rxSizeEccFault = 1'b0;
    rd(aSt, 32'h00001800);
    wr(aSt, 32'h00000000);
    rd(aSt, 32'h00001800);
    wr(aSt, 32'h00001000);
    rd(aSt, 32'h00000800);
    wr(aSt, 32'hFFFFFFFF);
    portLinkUp = 1'b1;
    rd(aSt, 32'h00000003);
    wr(aSt, 32'h00000001);
    rd(aSt, 32'h00000003);
    wr(aSt, 32'h00000002);
    rd(aSt, 32'h00000001);
    rxFrameEnd = 1'b1; step; rxFrameEnd = 1'b0; step; rxFrameStart = 1'b1; pulseQ.push_back(4'h1);
    step; rxFrameStart = 1'b0; rxFrameEnd = 1'b1; step; rxFrameEnd = 1'b0;
    repeat (40) step;
    rxFrameStart = 1'b1; step; rxFrameStart = 1'b0;
    rd(aSt, 32'h00000101);
    wr(aSt, 32'h00000100);
    wr(aMask, 32'h00000000, 1'b1);
    rd(aSt, 32'h00000401);
    rd(aMask, 32'h43FA1F1A);
    chunkMode = 1'b1;
    wr(aSt, 32'h00000400);
    wr(aMask, 32'h00000000, 1'b1);
    rd(aSt, 32'h00000001);
    normalFrameCount = 8'h01;
    rd(aSt, 32'h00000001);
    chunkMode = 1'b0;
    rd(aSt, 32'h00000011);
    urgentFrameCount = 8'h02;
    rd(aSt, 32'h00000031);
    chk_word("urgent first", 32'h00000001, {31'h0, deliverUrgentFirst});
    {urgentFrameCount, normalFrameCount, storeForward} = 17'h00000;
    cutThroughBytes = 16'h003F;
    rd(aSt, 32'h00000001);
    cutThroughBytes = 16'h0040;
    rd(aSt, 32'h00000011);
    cutThroughBytes = 16'h0000; eofReceived = 1'b1;
    rd(aSt, 32'h00000011);
    eofReceived = 1'b0;
    txFrameDone = 1'b1; step; txFrameDone = 1'b0;
    rd(aSt, 32'h00000009);
    wr(aSt, 32'h00000008);
    rd(aSt, 32'h00000001);
    txRdyOnEmpty = 1'b1; txFrameDone = 1'b1; step; txFrameDone = 1'b0;
    rd(aSt, 32'h00000001);
    txFifoEmpty = 1'b1; txFrameDone = 1'b1; step; txFrameDone = 1'b0;
    rd(aSt, 32'h00000009);
    wr(aMask, 32'h00000000);
    rd(aMask, 32'h43FA0000);
    chk_word("interrupt pin", 32'h00000000, {31'h0, interruptN});
    wr(aSt, 32'h00000008);
    chk_word("interrupt pin", 32'h00000001, {31'h0, interruptN});
    wr(aMask, 32'hFFFFFFFF);
    // credits read earlier bound how many chunks the host queues
    n = $urandom_range(95, 115);
    k = $urandom_range(1, 30);
    c = 119 - n + k;
    txChunkTaken = 1'b1; rxChunkStored = 1'b1; repeat (n) step; txChunkTaken = 1'b0; rxChunkStored = 1'b0;
    txChunkFreed = 1'b1; rxChunkRead = 1'b1; repeat (k) step; txChunkFreed = 1'b0; rxChunkRead = 1'b0;
    repeat (3) step;
    rd(aBuf, {16'h0000, 8'(c), 8'(n - k)});
    chk_word("footer credit", (c > 31) ? 31 : c, {27'h0, footerCredit});
    repeat (4) step;
    give_verdict;
  end
endmodule
